// *** design/pisr_event_status.sv ***
// Behaviour
// R01: latch events; record interrupt causes
// R02: read of cause register clears all bits
// R03: bit 15 on carrier monitor unstable
// R04: bit 14 on link status change
// R05: bit 13 on descrambler lock change
// R06: bit 12 on two idles in frame
// R07: bit 11 on link-loss counter MSB set
// R08: bit 10 on bad-delimiter counter MSB set
// R09: bit 9 on receive-error counter MSB set
// R10: bit 8 on buffer fault, abort frame
// R11: loopback elastic buffer ten bits deep
// R12: bit 7 when calibration finishes
// R13: cut long 10M transmission, set bit 6
// R14: jabber cleared by either status read
// R15: no jabber detection at 100 Mb/s
// R16: bit 5 on auto-negotiation complete
// R17: bit 4 on unstable legacy signalling
// R18: bit 3 on unadvertised parallel detection
// R19: bit 2 on remote or far-end fault
// R20: bit 1 on verified page received
// R21: reserved bit 0 reads zero
// R22: event beats simultaneous clearing read
module pisr_event_status
#(
    parameter int JAB_LIMIT = pisr_pkg::JAB_CYCLES,
    parameter int EB_DEPTH = pisr_pkg::EB_DEPTH
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [pisr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [pisr_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [pisr_pkg::DATA_W-1:0] rdata_o,
    input wire logic bmsr_read_i,
    // link and receive events
    input wire logic cim_unstable_i,
    input wire logic link_up_i,
    input wire logic descr_lock_i,
    input wire logic speed100_i,
    input wire logic in_frame_i,
    input wire logic sym_valid_i,
    input wire logic sym_idle_i,
    // counter most significant bits
    input wire logic link_loss_counter_msb_i,
    input wire logic bad_start_delimiter_counter_msb_i,
    input wire logic receive_error_counter_msb_i,
    // calibration and transmit
    input wire logic cal_done_i,
    input wire logic tx_active_i,
    output logic tx_cut_o,
    // auto-negotiation
    input wire logic an_enable_i,
    input wire logic an_done_i,
    input wire logic pd_fault_i,
    input wire logic par_fail_i,
    input wire logic lp_remote_fault_i,
    input wire logic fefi_i,
    input wire logic page_rx_i,
    // remote loopback elastic buffer
    input wire logic lb_active_i,
    input wire logic lb_wr_i,
    input wire logic lb_din_i,
    input wire logic lb_rd_i,
    output logic lb_dout_o,
    output logic lb_abort_o,
    // open-drain interrupt pin
    output logic irq_o,
    output logic irq_oe_n_o
);
    import pisr_pkg::*;

    // pointers and fill level are 4 bits wide
    if (EB_DEPTH < 2 || EB_DEPTH > 15)
    begin : g_bad_depth
        $error("elastic buffer depth out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // rising edge of a sampled level
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction : rise

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] cause_reg; // latched event causes
    logic [15:0] cause_next;
    logic [15:0] mask_reg; // pin enables per cause
    logic [15:0] evt; // this cycle's event set
    logic [15:0] clr; // this cycle's clear set
    logic [15:0] rdata_reg;
    logic rd_cause; // clearing read of the cause word
    // previous samples of level inputs
    logic link_prev_reg;
    logic lock_prev_reg;
    logic llc_prev_reg;
    logic bsd_prev_reg;
    logic rec_prev_reg;
    logic cal_prev_reg;
    logic an_prev_reg;
    logic rf_prev_reg;
    logic rf_src; // fault source picked by negotiation mode
    // premature end tracking
    logic idle_prev_reg; // last symbol in frame was idle
    logic prem_seen_reg; // one report per frame
    logic prem_evt;
    // jabber
    logic jab_evt;
    // elastic buffer
    logic [EB_DEPTH-1:0] eb_mem_reg;
    logic [3:0] eb_wp_reg;
    logic [3:0] eb_rp_reg;
    logic [3:0] eb_fill_reg;
    logic eb_abort_reg;
    logic eb_dout_reg;
    logic eb_ovr;
    logic eb_und;
    logic eb_fault;
    logic eb_wr_ok;
    logic eb_rd_ok;

    // ------------------------------------------------------------
    // jabber watchdog
    // ------------------------------------------------------------
    pisr_jabber_timer #(
        .LIMIT(JAB_LIMIT)
    ) u_jab (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tx_active_i(tx_active_i),
        .speed100_i(speed100_i),
        .jab_evt_o(jab_evt),
        .tx_cut_o(tx_cut_o)
    );

    // ------------------------------------------------------------
    // level input history for edge detection
    // ------------------------------------------------------------
    // all start low, so a level already high at release counts once
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            link_prev_reg <= 1'b0;
            lock_prev_reg <= 1'b0;
            llc_prev_reg <= 1'b0;
            bsd_prev_reg <= 1'b0;
            rec_prev_reg <= 1'b0;
            cal_prev_reg <= 1'b0;
            an_prev_reg <= 1'b0;
            rf_prev_reg <= 1'b0;
        end
        else
        begin
            link_prev_reg <= link_up_i;
            lock_prev_reg <= descr_lock_i;
            llc_prev_reg <= link_loss_counter_msb_i;
            bsd_prev_reg <= bad_start_delimiter_counter_msb_i;
            rec_prev_reg <= receive_error_counter_msb_i;
            cal_prev_reg <= cal_done_i;
            an_prev_reg <= an_done_i;
            rf_prev_reg <= rf_src;
        end
    end

    // fault source follows the negotiation mode
    assign rf_src = an_enable_i ? lp_remote_fault_i : fefi_i; // R19

    // ------------------------------------------------------------
    // premature end: two idles inside a 100 Mb/s frame
    // ------------------------------------------------------------
    assign prem_evt = speed100_i && in_frame_i && sym_valid_i
        && sym_idle_i && idle_prev_reg && !prem_seen_reg; // R06

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            idle_prev_reg <= 1'b0;
            prem_seen_reg <= 1'b0;
        end
        else if (!in_frame_i || !speed100_i)
        begin
            // delimiter ends the frame, history restarts
            idle_prev_reg <= 1'b0;
            prem_seen_reg <= 1'b0;
        end
        else if (sym_valid_i)
        begin
            idle_prev_reg <= sym_idle_i;
            if (prem_evt)
                prem_seen_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // remote loopback elastic buffer
    // ------------------------------------------------------------
    // depth covers twice the slip of a long frame at 100 ppm
    assign eb_ovr = lb_wr_i && !lb_rd_i
        && eb_fill_reg == 4'(EB_DEPTH); // R10
    assign eb_und = lb_rd_i && !lb_wr_i
        && eb_fill_reg == 4'h0; // R10
    assign eb_fault = lb_active_i && !eb_abort_reg && (eb_ovr || eb_und);
    assign eb_wr_ok = lb_active_i && !eb_abort_reg && lb_wr_i && !eb_ovr;
    assign eb_rd_ok = lb_active_i && !eb_abort_reg && lb_rd_i && !eb_und;

    // storage, one flop per bit slot
    genvar gi;
    generate
        for (gi = 0; gi < EB_DEPTH; gi++)
        begin : g_eb
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    eb_mem_reg[gi] <= 1'b0;
                else if (eb_wr_ok && eb_wp_reg == 4'(gi))
                    eb_mem_reg[gi] <= lb_din_i; // R11
            end
        end
    endgenerate

    // pointers, fill level, abort
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            eb_wp_reg <= 4'h0;
            eb_rp_reg <= 4'h0;
            eb_fill_reg <= 4'h0;
            eb_abort_reg <= 1'b0;
            eb_dout_reg <= 1'b0;
        end
        else if (!lb_active_i)
        begin
            // buffer empties between frames
            eb_wp_reg <= 4'h0;
            eb_rp_reg <= 4'h0;
            eb_fill_reg <= 4'h0;
            eb_abort_reg <= 1'b0;
            eb_dout_reg <= 1'b0;
        end
        else
        begin
            if (eb_fault)
                eb_abort_reg <= 1'b1; // R10
            if (eb_wr_ok)
                eb_wp_reg <= (eb_wp_reg == 4'(EB_DEPTH - 1)) ?
                    4'h0 : eb_wp_reg + 4'h1;
            if (eb_rd_ok)
            begin
                eb_rp_reg <= (eb_rp_reg == 4'(EB_DEPTH - 1)) ?
                    4'h0 : eb_rp_reg + 4'h1;
                eb_dout_reg <= eb_mem_reg[eb_rp_reg];
            end
            if (eb_wr_ok && !eb_rd_ok)
                eb_fill_reg <= eb_fill_reg + 4'h1;
            else if (eb_rd_ok && !eb_wr_ok)
                eb_fill_reg <= eb_fill_reg - 4'h1;
        end
    end

    assign lb_dout_o = eb_dout_reg;
    assign lb_abort_o = eb_abort_reg;

    // ------------------------------------------------------------
    // event set and clear vectors
    // ------------------------------------------------------------
    always_comb
    begin
        evt = 16'h0000;
        evt[B_CIM_UNSTABLE] = cim_unstable_i; // R03
        evt[B_LINK_CHG] = link_up_i ^ link_prev_reg; // R04
        evt[B_LOCK_CHG] = descr_lock_i ^ lock_prev_reg; // R05
        evt[B_PREM_END] = prem_evt; // R06
        evt[B_LLC_MSB] = rise(llc_prev_reg,
            link_loss_counter_msb_i); // R07
        evt[B_BSD_MSB] = rise(bsd_prev_reg,
            bad_start_delimiter_counter_msb_i); // R08
        evt[B_REC_MSB] = rise(rec_prev_reg,
            receive_error_counter_msb_i); // R09
        evt[B_LB_FAULT] = eb_fault; // R10
        evt[B_CAL_DONE] = rise(cal_prev_reg, cal_done_i); // R12
        evt[B_JABBER] = jab_evt && !speed100_i; // R15
        evt[B_AN_DONE] = rise(an_prev_reg, an_done_i); // R16
        evt[B_PD_FAULT] = pd_fault_i; // R17
        evt[B_PAR_FAIL] = par_fail_i; // R18
        evt[B_REM_FAULT] = rise(rf_prev_reg, rf_src); // R19
        evt[B_PAGE_RX] = page_rx_i; // R20
        evt[B_RSVD] = 1'b0; // R21
    end

    assign rd_cause = rd_i && addr_i == OFS_EVT_CAUSE;

    always_comb
    begin
        clr = 16'h0000;
        if (rd_cause)
            clr = 16'hFFFF; // R02
        if (bmsr_read_i)
            clr[B_JABBER] = 1'b1; // R14
    end

    // set wins over clear so no event is lost
    assign cause_next = ((cause_reg & ~clr) | evt)
        & ~(16'h0001 << B_RSVD); // R22

    // ------------------------------------------------------------
    // cause register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cause_reg <= RST_EVT_CAUSE;
        else
            cause_reg <= cause_next; // R01
    end

    // ------------------------------------------------------------
    // pin enable mask, software writable
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mask_reg <= RST_EVT_MASK;
        else if (wr_i && addr_i == OFS_EVT_MASK)
            mask_reg <= wdata_i & ~(16'h0001 << B_RSVD); // R21
    end

    // ------------------------------------------------------------
    // read data, valid only the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_reg <= 16'h0000;
        else if (!rd_i)
            rdata_reg <= 16'h0000;
        else
        begin
            case (addr_i)
                OFS_EVT_MASK: rdata_reg <= mask_reg;
                OFS_EVT_CAUSE: rdata_reg <= cause_reg; // R02
                OFS_SELF_STAT:
                begin
                    rdata_reg <= 16'h0000;
                    rdata_reg[SS_LINK] <= link_up_i; // R04
                    rdata_reg[SS_LOCK] <= descr_lock_i;
                    rdata_reg[SS_TX_CUT] <= tx_cut_o;
                end
                // unmapped words read as zero
                default: rdata_reg <= 16'h0000;
            endcase
        end
    end

    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // open-drain interrupt; enable low pulls the wire low
    // ------------------------------------------------------------
    assign irq_o = 1'b0;
    assign irq_oe_n_o = ~|(cause_reg & mask_reg); // R01

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_two_idles;
        (speed100_i && in_frame_i && sym_valid_i && sym_idle_i
            && !prem_seen_reg) ##1
        (speed100_i && in_frame_i && sym_valid_i && sym_idle_i);
    endsequence

    sequence s_clear_read;
        rd_cause && evt == 16'h0000 && !bmsr_read_i;
    endsequence

    property p_read_clears;
        s_clear_read |=> cause_reg == 16'h0000;
    endproperty
    a_read_clears: assert property (p_read_clears) // R02
        else $error("cause word not cleared by read");

    property p_read_value;
        rd_cause |=> rdata_o == $past(cause_reg);
    endproperty
    a_read_value: assert property (p_read_value) // R02
        else $error("read data differs from cause word");

    property p_set_wins;
        (rd_cause && evt != 16'h0000)
            |=> (cause_reg & $past(evt)) == $past(evt);
    endproperty
    a_set_wins: assert property (p_set_wins) // R22
        else $error("event lost during clearing read");

    property p_irq_pin;
        (evt & mask_reg) != 16'h0000 && !(wr_i && addr_i == OFS_EVT_MASK)
            |=> !irq_oe_n_o;
    endproperty
    a_irq_pin: assert property (p_irq_pin) // R01
        else $error("interrupt pin not pulled with cause set");

    property p_link_change;
        (link_up_i != $past(link_up_i)) |=> cause_reg[B_LINK_CHG];
    endproperty
    a_link_change: assert property (p_link_change) // R04
        else $error("link change not latched");

    property p_prem_end;
        s_two_idles |=> cause_reg[B_PREM_END];
    endproperty
    a_prem_end: assert property (p_prem_end) // R06
        else $error("premature end not latched");

    property p_no_jab_100;
        speed100_i [*2]
            |=> !cause_reg[B_JABBER] || $past(cause_reg[B_JABBER]);
    endproperty
    a_no_jab_100: assert property (p_no_jab_100) // R15
        else $error("jabber set at 100 Mb/s");

    property p_jab_cut;
        (jab_evt && !speed100_i) |-> tx_cut_o ##1 cause_reg[B_JABBER];
    endproperty
    a_jab_cut: assert property (p_jab_cut) // R13
        else $error("jabber without cut-off or latch");

    property p_bmsr_clear;
        (bmsr_read_i && !evt[B_JABBER]) |=> !cause_reg[B_JABBER];
    endproperty
    a_bmsr_clear: assert property (p_bmsr_clear) // R14
        else $error("jabber not cleared by basic status read");

    property p_eb_fault;
        eb_fault |=> lb_abort_o && cause_reg[B_LB_FAULT];
    endproperty
    a_eb_fault: assert property (p_eb_fault) // R10
        else $error("buffer fault not reported");

    property p_eb_depth;
        eb_fill_reg <= 4'(EB_DEPTH);
    endproperty
    a_eb_depth: assert property (p_eb_depth) // R11
        else $error("elastic buffer fill beyond depth");

    property p_rsvd_zero;
        // self status uses bit 0 for link, so only cause reads count
        !cause_reg[B_RSVD] && !($past(rd_cause) && rdata_o[B_RSVD]);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // R21
        else $error("reserved bit seen set");

endmodule : pisr_event_status

// *** design/pisr_pkg.sv ***
package pisr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] OFS_EVT_MASK = 5'h10;
    localparam logic [4:0] OFS_EVT_CAUSE = 5'h11;
    localparam logic [4:0] OFS_SELF_STAT = 5'h19;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_EVT_MASK = 16'h4080;
    localparam logic [15:0] RST_EVT_CAUSE = 16'h0000;

    // ------------------------------------------------------------
    // event cause bit positions
    // ------------------------------------------------------------
    localparam int B_CIM_UNSTABLE = 15;
    localparam int B_LINK_CHG = 14;
    localparam int B_LOCK_CHG = 13;
    localparam int B_PREM_END = 12;
    localparam int B_LLC_MSB = 11;
    localparam int B_BSD_MSB = 10;
    localparam int B_REC_MSB = 9;
    localparam int B_LB_FAULT = 8;
    localparam int B_CAL_DONE = 7;
    localparam int B_JABBER = 6;
    localparam int B_AN_DONE = 5;
    localparam int B_PD_FAULT = 4;
    localparam int B_PAR_FAIL = 3;
    localparam int B_REM_FAULT = 2;
    localparam int B_PAGE_RX = 1;
    localparam int B_RSVD = 0;

    // ------------------------------------------------------------
    // self status fields
    // ------------------------------------------------------------
    localparam int SS_LINK = 0;
    localparam int SS_LOCK = 1;
    localparam int SS_TX_CUT = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int JAB_TIME_MS = 105;
    localparam int JAB_CYCLES = JAB_TIME_MS * CLK_FREQ_KHZ;

    // ------------------------------------------------------------
    // loopback elastic buffer
    // ------------------------------------------------------------
    localparam int EB_DEPTH = 10;

endpackage : pisr_pkg

// *** design/pisr_jabber_timer.sv ***
module pisr_jabber_timer
#(
    parameter int LIMIT = pisr_pkg::JAB_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // transmit state
    input wire logic tx_active_i,
    input wire logic speed100_i,
    // results
    output logic jab_evt_o,
    output logic tx_cut_o
);
    import pisr_pkg::*;

    // counter is 24 bits wide; a limit below 2 cannot count at all
    if (LIMIT < 2 || LIMIT > 32'hFFFFFF)
    begin : g_bad_limit
        $error("jabber limit out of range");
    end

    logic [23:0] cnt_reg; // cycles of the current transmission
    logic cut_reg; // transmit cut off until it ends
    logic evt_reg; // one-cycle jabber pulse

    // ------------------------------------------------------------
    // transmission length counter, 10 Mb/s only
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_reg <= 24'h000000;
        else if (!tx_active_i || speed100_i)
            cnt_reg <= 24'h000000;
        else if (!cut_reg)
            cnt_reg <= cnt_reg + 24'h000001;
    end

    // ------------------------------------------------------------
    // cut-off held until transmit ends or 100 Mb/s is chosen; event pulses once
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cut_reg <= 1'b0;
            evt_reg <= 1'b0;
        end
        else
        begin
            evt_reg <= 1'b0;
            if (!tx_active_i || speed100_i)
                cut_reg <= 1'b0; // R15
            else if (!cut_reg && cnt_reg == 24'(LIMIT - 1))
            begin
                cut_reg <= 1'b1; // R13
                evt_reg <= 1'b1; // R13
            end
        end
    end

    assign jab_evt_o = evt_reg;
    assign tx_cut_o = cut_reg;

endmodule : pisr_jabber_timer

// *** tb/pisr_host.sv ***
// ----------------------------------------
// station management host, register side
// ----------------------------------------
module pisr_host
(
    // clock
    input wire logic clk_i,
    // register port
    output logic [pisr_pkg::ADDR_W-1:0] addr_o,
    output logic [pisr_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [pisr_pkg::DATA_W-1:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import pisr_pkg::*;

    // bus idle at time zero
    initial
    begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write; data inverted after so stale data never matches
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // one-cycle read; data stands only in the following cycle
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask : rd
endmodule : pisr_host

// *** tb/pisr_event_status_tb_top.sv ***
module pisr_event_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pisr_pkg::*;

    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk, nrst, wr, rd, irq, irq_oe_n, tx_cut, lb_dout, lb_abort;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, ev, v;
    // mode, frame, transmit and loopback controls
    logic spd, frm, sv, si, txa, ane, fefi, bmsr, lba, lbw, lbd, lbr;
    int err_count = 0;
    int checks_done = 0;
    // rows: event bit to pulse beside the cause value it should give
    logic [19:0] rows [12] = '{
        20'hF8000,
        20'hE4000,
        20'hD2000,
        20'hB0800,
        20'hA0400,
        20'h90200,
        20'h70080,
        20'h50020,
        20'h40010,
        20'h30008,
        20'h20004,
        20'h10002
    };

    pisr_event_status #(.JAB_LIMIT(20), .EB_DEPTH(10)) pisr_event_status_inst
    (
        .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bmsr_read_i(bmsr),
        .cim_unstable_i(ev[15]), .link_up_i(ev[14]), .descr_lock_i(ev[13]),
        .speed100_i(spd), .in_frame_i(frm), .sym_valid_i(sv),
        .sym_idle_i(si), .link_loss_counter_msb_i(ev[11]),
        .bad_start_delimiter_counter_msb_i(ev[10]),
        .receive_error_counter_msb_i(ev[9]), .cal_done_i(ev[7]),
        .tx_active_i(txa), .tx_cut_o(tx_cut), .an_enable_i(ane),
        .an_done_i(ev[5]), .pd_fault_i(ev[4]), .par_fail_i(ev[3]),
        .lp_remote_fault_i(ev[2]), .fefi_i(fefi), .page_rx_i(ev[1]),
        .lb_active_i(lba), .lb_wr_i(lbw), .lb_din_i(lbd), .lb_rd_i(lbr),
        .lb_dout_o(lb_dout), .lb_abort_o(lb_abort), .irq_o(irq),
        .irq_oe_n_o(irq_oe_n)
    );

    pisr_host pisr_host_inst
    (
        .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // ----------------------------------------
    // compare, read and closing helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        pisr_host_inst.rd(a, d);
        chk(d, exp);
    endtask : rc

    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // hang guard, far beyond the expected run
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        ev = '0;
        {spd, frm, sv, si, txa, fefi, bmsr, lba, lbw, lbd, lbr} = '0;
        ane = 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(irq_oe_n, 1'b1);
        chk(irq, 1'b0);
        rc(5'h10, 16'h4080);
        rc(5'h11, 16'h0000);
        rc(5'h1F, 16'h0000);
        pisr_host_inst.wr(5'h10, 16'hFFFF);
        rc(5'h10, 16'hFFFE);
        pisr_host_inst.wr(5'h11, 16'hFFFF);
        rc(5'h11, 16'h0000);
        // each event alone, then read clears it
        foreach (rows[i])
        begin
            @(posedge clk);
            ev <= 16'h1 << rows[i][19:16];
            @(posedge clk);
            ev <= '0;
            repeat (2) @(posedge clk);
            #1 chk(irq_oe_n, 1'b0);
            rc(5'h11, rows[i][15:0]);
            chk(irq_oe_n, 1'b1);
            rc(5'h11, 16'h0000);
        end
        // event in the very cycle of the clearing read
        fork
            pisr_host_inst.rd(5'h11, v);
            begin
                @(posedge clk);
                ev[1] <= 1'b1;
                @(posedge clk);
                ev[1] <= 1'b0;
            end
        join
        chk(v, 16'h0000);
        rc(5'h11, 16'h0002);
        // two idles inside a 100M frame
        @(posedge clk);
        {spd, frm, sv, si} <= 4'hF;
        repeat (2) @(posedge clk);
        {frm, sv, si} <= 3'h0;
        rc(5'h11, 16'h1000);
        // jabber at 10M, then cleared by the basic status read
        spd <= 1'b0;
        txa <= 1'b1;
        repeat (25) @(posedge clk);
        #1 chk(tx_cut, 1'b1);
        rc(5'h19, 16'h0004);
        @(posedge clk);
        bmsr <= 1'b1;
        @(posedge clk);
        {bmsr, txa} <= 2'b00;
        rc(5'h11, 16'h0000);
        // no jabber at 100M however long
        spd <= 1'b1;
        txa <= 1'b1;
        repeat (25) @(posedge clk);
        #1 chk(tx_cut, 1'b0);
        txa <= 1'b0;
        rc(5'h11, 16'h0000);
        // far-end fault counts only with negotiation off
        ane <= 1'b0;
        fefi <= 1'b1;
        rc(5'h11, 16'h0004);
        {ane, fefi} <= 2'b10;
        // with negotiation on, a far-end fault must be ignored
        @(posedge clk);
        fefi <= 1'b1;
        rc(5'h11, 16'h0000);
        fefi <= 1'b0;
        // loopback buffer: ten bits fit, the eleventh overruns
        @(posedge clk);
        {lba, lbw, lbd} <= 3'h7;
        repeat (10) @(posedge clk);
        lbw <= 1'b0;
        @(posedge clk);
        #1 chk(lb_abort, 1'b0);
        @(posedge clk);
        lbw <= 1'b1;
        @(posedge clk);
        lbw <= 1'b0;
        @(posedge clk);
        #1 chk(lb_abort, 1'b1);
        rc(5'h11, 16'h0100);
        // new frame: one bit in, read back, second read underruns
        @(posedge clk);
        lba <= 1'b0;
        @(posedge clk);
        {lba, lbw, lbd} <= 3'h7;
        @(posedge clk);
        {lbw, lbr} <= 2'b01;
        repeat (2) @(posedge clk);
        lbr <= 1'b0;
        #1 chk(lb_dout, 1'b1);
        chk(lb_abort, 1'b1);
        rc(5'h11, 16'h0100);
        lba <= 1'b0;
        wrap_up();
    end
endmodule : pisr_event_status_tb_top
